// *** bench/tcp_assertions.sv ***
// Purpose: port-level checks on the pwm register block
// Assumes: one pclk domain, presetn active low
// Notes:   attached to tcp_top by the bind at the foot
`timescale 1ns/1ps
module tcp_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        rc_tick,
  input wire logic [2:0]  pwm_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup cycle seen by the slave
  wire setup = psel && !penable && clk_en;
  a_ready_next: assert property (setup |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_nodata: assert property (pslverr |-> pready && prdata == 0)
    else $error("error without ready or with data");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 0)
    else $error("upper read bits not zero");
  a_misalign_err: assert property (setup && paddr[1:0] != 0 |=> pslverr)
    else $error("misaligned access not refused");
  a_mapped_ok: assert property (setup && paddr == 12'h268 |=> !pslverr)
    else $error("mapped access refused");
  a_pins_reset: assert property ($rose(presetn) |-> pwm_out == 0)
    else $error("pins not low after reset");
endmodule
bind tcp_top tcp_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rc_tick(rc_tick), .pwm_out(pwm_out));

// *** bench/tcp_top_tb.sv ***
// Purpose: register and pin tests of the pwm block over apb
// Assumes: answer comes when pready is seen high
// Notes:   rc ticks every third pclk
`timescale 1ns/1ps
module tcp_top_tb;
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic        rc_tick = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er;
  logic [2:0]  pwm_out;
  logic [1:0]  rc_cnt = 2'h0;
  int          errors, checks;
  logic [31:0] h0, h1, h2;
  logic [7:0]  ix [9] = '{8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f,
                          8'ha1, 8'ha6, 8'ha7};
  logic [7:0]  rv [9] = '{8'hff, 8'h80, 8'hff, 8'h80, 8'hff, 8'h80,
                          8'h88, 8'h00, 8'h08};
  logic [7:0]  mk [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                          8'hff, 8'hc0, 8'h1f};
  int          lt [4] = '{16, 8, 4, 12};
  tcp_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_tick(rc_tick), .pwm_out(pwm_out));
  // clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // internal rc clock pulse every third cycle
  always @(posedge pclk) begin
    rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    rc_tick <= (rc_cnt == 2'h2);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask
  task automatic rdx(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, {2'b00, i, 2'b00}, 8'h0);
    chk(rd, {24'h0, e});
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    #40000;
    errors++;
    test_done();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite} = '0;
    {clk_en, paddr, pwdata} = {1'b1, 12'h0, 32'h0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++)
      rdx(ix[i], rv[i]);
    foreach (rv[p]) if (p < 2) begin
      for (int i = 0; i < 9; i++) wr(ix[i], p ? 8'ha5 : 8'h5a);
      for (int i = 0; i < 9; i++)
        rdx(ix[i], mk[i] & (p ? 8'ha5 : 8'h5a));
    end
    apb(1'b0, 12'h2a0, 8'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h269, 8'h11);
    chk({31'h0, er}, 32'h1);
    rdx(8'h9a, 8'ha5);
    wr(8'ha6, 8'h00);
    for (int i = 0; i < 6; i++) wr(ix[i], i[0] ? 8'h02 : 8'h03);
    // each clock source: ch0 duty 8, ch1 duty 9, ch2 duty 10, period 3
    for (int c = 0; c < 4; c++) begin
      wr(8'ha1, {c[1:0], 2'b01, c[1:0], 2'b00});
      wr(8'ha7, {3'b001, c[1:0], 2'b10});
      wr(8'ha6, 8'hc0);
      repeat (2 * lt[c] + 8) @(posedge pclk);
      {h0, h1, h2} = '0;
      repeat (2 * lt[c]) begin
        @(posedge pclk);
        h0 += pwm_out[0];
        h1 += pwm_out[1];
        h2 += pwm_out[2];
      end
      chk(h0, lt[c]);
      chk(h1, 3 * lt[c] / 2);
      chk(h2, 3 * lt[c] / 2);
    end
    // clock enable low: pins and counters hold their state
    clk_en <= 1'b0;
    @(posedge pclk);
    h0 = {29'h0, pwm_out};
    repeat (20) begin
      @(posedge pclk);
      chk({29'h0, pwm_out}, h0);
    end
    clk_en <= 1'b1;
    wr(8'ha6, 8'h00);
    wr(8'ha7, 8'h00);
    repeat (3) @(posedge pclk);
    chk({29'h0, pwm_out}, 32'h0);
    test_done();
  end
endmodule

// *** rtl/tcp_ch_if.sv ***
// Purpose: carries one channel's settings and output between modules
// Assumes: all signals in the pclk domain
// Notes:   ctrl side drives settings, chan side returns the pin level
`timescale 1ns/1ps
interface tcp_ch_if;
  logic [7:0] period;
  logic [9:0] duty;
  logic [1:0] cks;
  logic       enable;
  logic       rc_tick;
  logic       pwm_out;
  modport ctrl (output period, duty, cks, enable, rc_tick, input pwm_out);
  modport chan (input period, duty, cks, enable, rc_tick, output pwm_out);
endinterface

// *** rtl/tcp_channel.sv ***
// Purpose: one pwm channel: prescaler, period counter, duty compare
// Assumes: rc_tick is a one-cycle pulse per internal rc clock edge
// Notes:   period and duty are taken into shadows at each period boundary
`timescale 1ns/1ps
module tcp_channel (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // settings and output
  tcp_ch_if.chan    ch
);
  logic [1:0] presc_r, presc_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] per_r, per_nxt;
  logic [9:0] duty_r, duty_nxt;
  logic       out_r, out_nxt;
  logic       tick;

  // next state: count selected clock, reload shadows on wrap
  always_comb begin
    presc_nxt = presc_r + 2'h1;
    cnt_nxt   = cnt_r;
    per_nxt   = per_r;
    duty_nxt  = duty_r;
    case (ch.cks)
      tcp_pkg::CKS_DIV4: tick = (presc_r == tcp_pkg::PRESC_LAST);
      tcp_pkg::CKS_DIV2: tick = presc_r[0];
      tcp_pkg::CKS_SYS:  tick = 1'b1;
      default:           tick = ch.rc_tick;
    endcase
    if (!ch.enable) begin
      // disabled: hold at start, track settings, pin low
      presc_nxt = 2'h0;
      cnt_nxt   = 8'h00;
      per_nxt   = ch.period;
      duty_nxt  = ch.duty;
    end else if (tick) begin
      if (cnt_r >= per_r) begin
        cnt_nxt  = 8'h00;
        per_nxt  = ch.period;
        duty_nxt = ch.duty;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
    out_nxt = ch.enable && ({cnt_nxt, 2'b00} < duty_nxt);
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 2'h0;
      cnt_r   <= 8'h00;
      per_r   <= tcp_pkg::RST_PERIOD;
      duty_r  <= {tcp_pkg::RST_DUTYH, tcp_pkg::RST_DUTYL};
      out_r   <= 1'b0;
    end else if (clk_en) begin
      presc_r <= presc_nxt;
      cnt_r   <= cnt_nxt;
      per_r   <= per_nxt;
      duty_r  <= duty_nxt;
      out_r   <= out_nxt;
    end
  end

  assign ch.pwm_out = out_r;
endmodule

// *** rtl/tcp_pkg.sv ***
// Purpose: constants shared by the three-channel pwm register block
// Assumes: apb byte address = 4 * register index, one register per word
// Notes:   register data sits in bits 7..0, upper bits read as zero
package tcp_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_CH0_PERIOD = 8'h9a;
  localparam logic [7:0] IDX_CH0_DUTYH  = 8'h9b;
  localparam logic [7:0] IDX_CH1_PERIOD = 8'h9c;
  localparam logic [7:0] IDX_CH1_DUTYH  = 8'h9d;
  localparam logic [7:0] IDX_CH2_PERIOD = 8'h9e;
  localparam logic [7:0] IDX_CH2_DUTYH  = 8'h9f;
  localparam logic [7:0] IDX_SHARED     = 8'ha1;
  localparam logic [7:0] IDX_PIN_CTRL   = 8'ha6;
  localparam logic [7:0] IDX_CH2_CTRL   = 8'ha7;
  localparam int         ADDR_W         = 10;
  // reset values
  localparam logic [7:0] RST_PERIOD     = 8'hff;
  localparam logic [7:0] RST_DUTYH      = 8'h80;
  localparam logic [1:0] RST_DUTYL      = 2'h0;
  localparam logic [1:0] RST_CKS        = 2'h2;
  // field positions
  localparam int SH_CH1_CKS   = 6;
  localparam int SH_CH1_DUTYL = 4;
  localparam int SH_CH0_CKS   = 2;
  localparam int SH_CH0_DUTYL = 0;
  localparam int C2_EN        = 4;
  localparam int C2_CKS       = 2;
  localparam int C2_DUTYL     = 0;
  localparam int PC_CH1_EN    = 7;
  localparam int PC_CH0_EN    = 6;
  // clock source encodings
  localparam logic [1:0] CKS_DIV4 = 2'h0;
  localparam logic [1:0] CKS_DIV2 = 2'h1;
  localparam logic [1:0] CKS_SYS  = 2'h2;
  localparam logic [1:0] CKS_RC   = 2'h3;
  localparam logic [1:0] PRESC_LAST = 2'h3;
endpackage

// *** rtl/tcp_top.sv ***
// Purpose: three-channel pwm generator with its registers on apb
// Assumes: rc_tick synchronous to pclk; no wait states on apb
// Notes:   answers one cycle after setup; unmapped address gives pslverr
//          misaligned or out-of-window addresses are refused as well
//          each register is one word at byte address four times its index
//          only bits 7..0 of a word hold state; bits 31..8 read as zero
//          a refused access writes nothing and returns zero data
//          read data is captured at setup and holds until the next setup
//          back-to-back transfers need no idle cycle between them
//          clk_en low stalls the bus answer and freezes every channel
//          rc_tick is a single-cycle pulse already in the pclk domain
//          unlisted bits of pin control and ch2 control read as zero
//          duty is the duty-high word above its two duty-low bits
//          new period and duty take effect at the next period boundary
//          the pins are active high and low while disabled
// How it works
// - each channel has an 8-bit read/write period, reset to ff
// - duty is 10 bits; bits 9..2 in own register, reset to 80
// - channel 0 duty bits 1..0 live in shared bits 1..0, reset 0
// - channel 1 duty bits 1..0 live in shared bits 5..4, reset 0
// - clock selects at shared 7..6 and 3..2: /4, /2, sys, rc; reset sys
// - channel 2 clock select and low duty in its own control register
// - channel 0 runs and drives its pin only while pin-control bit 6 set
// - channel 1 runs and drives its pin only while pin-control bit 7 set
// - channel 2 runs and drives its pin only while control bit 4 set
`timescale 1ns/1ps
module tcp_top (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // internal rc clock tick and pwm pins
  input  wire logic        rc_tick,
  output logic      [2:0]  pwm_out
);
  // per-channel settings as software sees them
  logic [7:0]  per_r   [3];
  logic [7:0]  per_nxt [3];
  logic [7:0]  dh_r    [3];
  logic [7:0]  dh_nxt  [3];
  logic [1:0]  dl_r    [3];
  logic [1:0]  dl_nxt  [3];
  logic [1:0]  cks_r   [3];
  logic [1:0]  cks_nxt [3];
  logic [2:0]  en_r, en_nxt;

  // bus answer, registered so the outputs come from flops
  logic [31:0] rd_r, rd_nxt;
  logic        rdy_r, rdy_nxt;
  logic        err_r, err_nxt;

  // decode helpers
  logic [7:0]  rdv;
  logic        hit;
  logic        wr;
  logic [7:0]  idx;
  logic [7:0]  wd;

  // bus phases as this slave sees them
  logic        setup;
  logic        access;

  // word index, low data lane and the two bus phases
  assign idx    = paddr[tcp_pkg::ADDR_W-1:2];
  assign wd     = pwdata[7:0];
  assign setup  = psel && !penable;
  assign access = psel && penable && rdy_r;
  // a write lands only in the access cycle of a mapped word
  assign wr     = access && pwrite && !err_r;

  // address decode and read mux
  // unmapped words read as zero and raise pslverr at the answer
  always_comb begin
    hit = 1'b1;
    rdv = 8'h00;
    // refuse misaligned words and anything above the decoded window
    if (paddr[1:0] != 2'b00 || paddr[11:tcp_pkg::ADDR_W] != 2'b00) begin
      hit = 1'b0;
    // channel period and duty-high words
    end else if (idx == tcp_pkg::IDX_CH0_PERIOD) begin
      rdv = per_r[0];
    end else if (idx == tcp_pkg::IDX_CH0_DUTYH) begin
      rdv = dh_r[0];
    end else if (idx == tcp_pkg::IDX_CH1_PERIOD) begin
      rdv = per_r[1];
    end else if (idx == tcp_pkg::IDX_CH1_DUTYH) begin
      rdv = dh_r[1];
    end else if (idx == tcp_pkg::IDX_CH2_PERIOD) begin
      rdv = per_r[2];
    end else if (idx == tcp_pkg::IDX_CH2_DUTYH) begin
      rdv = dh_r[2];
    // shared word: ch1 fields above ch0 fields
    end else if (idx == tcp_pkg::IDX_SHARED) begin
      rdv = {cks_r[1], dl_r[1], cks_r[0], dl_r[0]};
    // pin control: enables in bits 7 and 6, the rest zero
    end else if (idx == tcp_pkg::IDX_PIN_CTRL) begin
      rdv = {en_r[1], en_r[0], 6'h00};
    // ch2 control: enable, clock select, duty-low
    end else if (idx == tcp_pkg::IDX_CH2_CTRL) begin
      rdv = {3'h0, en_r[2], cks_r[2], dl_r[2]};
    // nothing is mapped at any other index
    end else begin
      hit = 1'b0;
    end
  end

  // apb handshake: answer in the cycle after setup
  // pready rises in the access cycle that follows a setup taken while clk_en is high
  // pslverr marks a refused word in that same cycle
  always_comb begin
    rdy_nxt = setup;
    err_nxt = setup && !hit;
    // read data is captured at setup and then holds
    rd_nxt  = rd_r;
    if (setup) begin
      rd_nxt = {24'h0000_00, hit ? rdv : 8'h00};
    end
  end

  // register writes
  // every field of a word is written together; others keep their value
  always_comb begin
    per_nxt = per_r;
    dh_nxt  = dh_r;
    dl_nxt  = dl_r;
    cks_nxt = cks_r;
    en_nxt  = en_r;
    if (wr) begin
      // channel period and duty-high words
      if (idx == tcp_pkg::IDX_CH0_PERIOD) begin
        per_nxt[0] = wd;
      end else if (idx == tcp_pkg::IDX_CH0_DUTYH) begin
        dh_nxt[0] = wd;
      end else if (idx == tcp_pkg::IDX_CH1_PERIOD) begin
        per_nxt[1] = wd;
      end else if (idx == tcp_pkg::IDX_CH1_DUTYH) begin
        dh_nxt[1] = wd;
      end else if (idx == tcp_pkg::IDX_CH2_PERIOD) begin
        per_nxt[2] = wd;
      end else if (idx == tcp_pkg::IDX_CH2_DUTYH) begin
        dh_nxt[2] = wd;
      // shared word: clock selects and duty-low bits of ch0 and ch1
      end else if (idx == tcp_pkg::IDX_SHARED) begin
        dl_nxt[0]  = wd[tcp_pkg::SH_CH0_DUTYL +: 2];
        dl_nxt[1]  = wd[tcp_pkg::SH_CH1_DUTYL +: 2];
        cks_nxt[0] = wd[tcp_pkg::SH_CH0_CKS +: 2];
        cks_nxt[1] = wd[tcp_pkg::SH_CH1_CKS +: 2];
      // pin control: only the two channel enables are stored
      end else if (idx == tcp_pkg::IDX_PIN_CTRL) begin
        en_nxt[0] = wd[tcp_pkg::PC_CH0_EN];
        en_nxt[1] = wd[tcp_pkg::PC_CH1_EN];
      // ch2 control: enable, clock select and duty-low bits
      end else if (idx == tcp_pkg::IDX_CH2_CTRL) begin
        en_nxt[2]  = wd[tcp_pkg::C2_EN];
        cks_nxt[2] = wd[tcp_pkg::C2_CKS +: 2];
        dl_nxt[2]  = wd[tcp_pkg::C2_DUTYL +: 2];
      end
    end
  end

  // state registers
  // clk_en low freezes every register, the bus answer included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // settings come up at the longest period, sys clock, disabled
      for (int i = 0; i < 3; i++) begin
        per_r[i] <= tcp_pkg::RST_PERIOD;
        dh_r[i]  <= tcp_pkg::RST_DUTYH;
        dl_r[i]  <= tcp_pkg::RST_DUTYL;
        cks_r[i] <= tcp_pkg::RST_CKS;
      end
      en_r  <= 3'h0;
      // bus answer idle after reset
      rd_r  <= 32'h0000_0000;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
    end else if (clk_en) begin
      per_r <= per_nxt;
      dh_r  <= dh_nxt;
      dl_r  <= dl_nxt;
      cks_r <= cks_nxt;
      en_r  <= en_nxt;
      rd_r  <= rd_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
    end
  end

  // bus outputs come straight from their flops
  assign prdata  = rd_r;
  assign pready  = rdy_r;
  assign pslverr = err_r;

  // one channel instance per pwm pin
  // settings travel through one interface per channel; the rc tick is
  // shared, so every channel sees the same pulse on the same edge
  tcp_ch_if ch_if [3] ();
  for (genvar g = 0; g < 3; g++) begin : g_ch
    assign ch_if[g].period  = per_r[g];
    assign ch_if[g].duty    = {dh_r[g], dl_r[g]};
    assign ch_if[g].cks     = cks_r[g];
    assign ch_if[g].enable  = en_r[g];
    assign ch_if[g].rc_tick = rc_tick;
    assign pwm_out[g]       = ch_if[g].pwm_out;
    // the channel registers its own pin, so each output is a flop
    tcp_channel u_ch (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .ch      (ch_if[g])
    );
  end
endmodule
